// ---- core/mad_core.sv ----
/*
  Multiply/ALU instruction datapath: multiplier, ALU, accumulators, x/y/p,
  pointer post-modification and RAM write-back of one-word instructions.
  Assumes the sequencer presents ROM and RAM read data with the instruction,
  read at the current pointers, and completes RAM writes from ram_wr_o.
*/
// Contract
// [RQ1] function and transfer of one instruction execute in parallel
// [RQ2] any function/transfer pair, or either alone, is accepted
// [RQ3] p takes the signed product of x and y high half
// [RQ4] multiply-accumulate loads x,y, multiplies old operands, accumulates old p
// [RQ5] ALU does and, or, xor, add, subtract and load with y
// [RQ6] every instruction is one word
// [RQ7] transfers writing RAM take two cycles, cached or not
// [RQ8] dual reads take two cycles uncached, one cached
// [RQ9] no transfer or single read completes in one cycle
// [RQ10] nop is the all-zero word, one cycle, no state change
// [RQ11] accumulator selects pick one of exactly two accumulators
// [RQ12] x reads ROM at rom pointer, then pointer adds one or step
// [RQ13] y uses one of four RAM pointers, modified 0,+1,-1 or j
// [RQ14] compound forms modify twice: 0/+1, +1/0, -1/+2, j/k
// [RQ15] compound saves register, reads RAM into it, writes saved value back
// [RQ16] high-half loads clear low half when its clear bit is zero
// [RQ17] low-half loads keep the high half
// [RQ18] y and p are sign-extended before any ALU operation
// [RQ19] accumulators are 36 bits, extension fills every upper bit
// [RQ20] compare forms set flags but write no accumulator
// [RQ21] functions set flags, transfer loads leave flags alone; the code sets no flags for F_MUL
// [RQ22] functions see register values from before the instruction
`timescale 1ns/1ns
`default_nettype none
`include "mad_consts.svh"

module mad_core
    import mad_pkg::*;
(
    input  wire logic                  clock_i,             // 100 MHz
    input  wire logic                  resetn_i,            // async, low
    input  wire logic                  instr_valid_i,       // word offered
    input  wire logic [`MAD_IW-1:0]    instr_i,             // one-word instr
    input  wire logic                  in_cache_i,          // runs from cache
    input  wire logic [`MAD_HW-1:0]    rom_rdata_i,         // at rom pointer
    input  wire logic [`MAD_HW-1:0]    ram_rdata_i,         // at selected ptr
    input  wire logic [`MAD_HW-1:0]    rom_step_i,          // rom step
    input  wire logic [`MAD_HW-1:0]    ram_step_j_i,        // j step
    input  wire logic [`MAD_HW-1:0]    ram_step_k_i,        // k step
    input  wire logic [2:0]            low_half_clear_ctrl_i, // 0 = clear
    output var  logic                  instr_ready_o,       // may take
    output var  logic                  instr_done_o,        // last cycle
    output var  logic                  ram_wr_o,            // write pulse
    output var  logic [`MAD_HW-1:0]    ram_waddr_o,         // write address
    output var  logic [`MAD_HW-1:0]    ram_wdata_o,         // write data
    output var  logic [`MAD_HW-1:0]    rom_pointer_o,       // x address
    output var  logic [3:0][`MAD_HW-1:0] ram_pointer_reg_o, // four pointers
    output var  logic [`MAD_HW-1:0]    x_o,                 // x register
    output var  logic [`MAD_REG_W-1:0] y_o,                 // y register
    output var  logic [`MAD_REG_W-1:0] p_o,                 // product
    output var  logic [`MAD_ACC_W-1:0] accum_zero_o,        // accumulator 0
    output var  logic [`MAD_ACC_W-1:0] accum_one_o,         // accumulator 1
    output var  logic [3:0]            flags_o              // mv,lv,eq,mi
);

// ==========================================================
// reset release
logic rst_q1;
logic rst_n;
always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        rst_q1 <= 1'b0;
        rst_n  <= 1'b0;
    end else begin
        rst_q1 <= 1'b1;
        rst_n  <= rst_q1;
    end
end

// ==========================================================
// decode helpers
function automatic logic f_ram_wr(input mad_xfer_t t);
    f_ram_wr = (t >= T_STY);
endfunction

function automatic logic f_dual(input mad_xfer_t t);
    f_dual = (t == T_LDY_X) || (t == T_YACC_X);
endfunction

function automatic logic f_is_z(input mad_xfer_t t);
    f_is_z = (t >= T_ZY_X);
endfunction

function automatic logic f_mul(input mad_func_t f);
    f_mul = (f >= F_MUL) && (f <= F_SUBP_MUL);
endfunction

// ==========================================================
// instruction fields
mad_func_t  fn;
mad_xfer_t  xf;
mad_zmode_t zm;
wire        as_sel = instr_i[`MAD_AS_BIT]; // [RQ11]
wire        ad_sel = instr_i[`MAD_AD_BIT];
wire        at_sel = instr_i[`MAD_AT_BIT];
wire [1:0]  psel   = instr_i[`MAD_PSEL_HI:`MAD_PSEL_LO];
wire [1:0]  ym     = instr_i[`MAD_YM_HI:`MAD_YM_LO];
wire        xm     = instr_i[`MAD_XM_BIT];
assign fn = mad_func_t'(instr_i[`MAD_F_HI:`MAD_F_LO]); // [RQ2]
assign xf = mad_xfer_t'(instr_i[`MAD_T_HI:`MAD_T_LO]);
assign zm = mad_zmode_t'(ym);

wire take      = instr_valid_i & instr_ready_o;
wire is_wr     = f_ram_wr(xf);
wire is_dual   = f_dual(xf);
wire is_z      = f_is_z(xf);
wire two_cyc   = is_wr | (is_dual & ~in_cache_i); // [RQ7] [RQ8] [RQ9]
wire is_mul    = f_mul(fn);

// ==========================================================
// data arithmetic unit
wire [`MAD_ACC_W-1:0] acc_cur [2];
assign acc_cur[0] = accum_zero_o;
assign acc_cur[1] = accum_one_o;

// old register values only: the same edge may reload them [RQ22]
wire [`MAD_ACC_W-1:0] acc_s = acc_cur[as_sel];
wire [`MAD_ACC_W-1:0] at_v  = acc_cur[at_sel];
wire [`MAD_ACC_W-1:0] p_ext = {{`MAD_GUARD{p_o[31]}}, p_o}; // [RQ18] [RQ19]
wire [`MAD_ACC_W-1:0] y_ext = {{`MAD_GUARD{y_o[31]}}, y_o}; // [RQ18] [RQ19]
wire use_p = (fn >= F_LDP_MUL) && (fn <= F_SUBP);
wire [`MAD_ACC_W-1:0] opnd = use_p ? p_ext : y_ext;

wire [`MAD_ACC_W-1:0] sum  = acc_s + opnd;
wire [`MAD_ACC_W-1:0] diff = acc_s - opnd;
wire is_add = (fn == F_ADDP_MUL) || (fn == F_ADDP) || (fn == F_ADDY);
wire is_sub = (fn == F_SUBP_MUL) || (fn == F_SUBP) || (fn == F_SUBY)
           || (fn == F_CMPSUB);
wire is_ld  = (fn == F_LDP_MUL) || (fn == F_LDP) || (fn == F_LDY);
wire is_and = (fn == F_ANDY) || (fn == F_CMPAND);

wire [`MAD_ACC_W-1:0] res =                                  // [RQ5]
      is_add          ? sum
    : is_sub          ? diff
    : is_ld           ? opnd
    : is_and          ? (acc_s & y_ext)
    : (fn == F_ORY)   ? (acc_s | y_ext)
    :                   (acc_s ^ y_ext);

// 36-bit overflow from sign agreement, no extra adder bit needed
wire ov_add = (acc_s[35] == opnd[35]) && (sum[35] != acc_s[35]);
wire ov_sub = (acc_s[35] != opnd[35]) && (diff[35] != acc_s[35]);
wire f_llv  = (is_add & ov_add) | (is_sub & ov_sub);
wire f_lmv  = ~((&res[35:31]) | ~(|res[35:31]));
wire [3:0] next_flags = {f_lmv, f_llv, (res == `MAD_ACC_RST), res[35]};

wire fn_flags = (fn != F_NONE) && (fn != F_MUL);             // [RQ21]
wire fn_wr    = fn_flags && (fn != F_CMPSUB) && (fn != F_CMPAND); // [RQ20]

wire signed [`MAD_REG_W-1:0] product =
    $signed(x_o) * $signed(y_o[31:16]);                      // [RQ3]

// ==========================================================
// address arithmetic
wire [`MAD_HW-1:0] rp = ram_pointer_reg_o[psel];
wire [`MAD_HW-1:0] step1 =                                   // [RQ13]
      (ym == 2'h0) ? `MAD_HALF0
    : (ym == 2'h1) ? `MAD_PLUS1
    : (ym == 2'h2) ? `MAD_MINUS1
    :                ram_step_j_i;
wire [`MAD_HW-1:0] step2 =                                   // [RQ14]
      (zm == compound_read_then_incr)     ? `MAD_PLUS1
    : (zm == compound_incr_then_write)    ? `MAD_HALF0
    : (zm == compound_decr_then_plus_two) ? `MAD_PLUS2
    :                                       ram_step_k_i;
wire [`MAD_HW-1:0] rp_mid = rp + step1;
wire [`MAD_HW-1:0] next_rp = is_z ? rp_mid + step2 : rp_mid;
wire uses_rp = (xf != T_NONE) && (xf != T_YACC_X);            // [RQ10]
wire uses_x  = (xf == T_LDY_X) || (xf == T_YACC_X) || (xf == T_ZY_X);
wire [`MAD_HW-1:0] next_rom =                                // [RQ12]
    rom_pointer_o + (xm ? rom_step_i : `MAD_PLUS1);

// ==========================================================
// transfer loads
wire y_hi_ld = (xf == T_LDY_X) || (xf == T_YACC_X) || (xf == T_ZY_X)
            || (xf == T_ZY);
wire y_lo_ld = (xf == T_LDYL) || (xf == T_ZYL);
wire a_hi_ld = (xf == T_LDACC) || (xf == T_ZACC);
wire a_lo_ld = (xf == T_LDACCL) || (xf == T_ZACCL);
wire x_ld    = uses_x || (xf == T_LDX);

wire [`MAD_HW-1:0] y_hi_src = (xf == T_YACC_X) ? at_v[31:16] : ram_rdata_i;
wire [`MAD_HW-1:0] y_lo_keep =
    low_half_clear_ctrl_i[`MAD_LOWCLR_Y] ? y_o[15:0] : `MAD_HALF0; // [RQ16]
wire [`MAD_REG_W-1:0] next_y =
      y_hi_ld ? {y_hi_src, y_lo_keep}
    : y_lo_ld ? {y_o[31:16], ram_rdata_i}                   // [RQ17]
    :           y_o;
wire [`MAD_HW-1:0] next_x = (xf == T_LDX) ? ram_rdata_i : rom_rdata_i;

// saved value of the register, written after its reload [RQ15]
wire [`MAD_HW-1:0] next_wdata =
      ((xf == T_STY)  || (xf == T_ZY) || (xf == T_ZY_X)) ? y_o[31:16]
    : ((xf == T_STYL) || (xf == T_ZYL))                  ? y_o[15:0]
    : ((xf == T_STACC) || (xf == T_ZACC))                ? at_v[31:16]
    :                                                      at_v[15:0];
wire [`MAD_HW-1:0] next_waddr = is_z ? rp_mid : rp;

// per accumulator: a transfer load wins over a function result
wire [`MAD_ACC_W-1:0] next_acc [2];
genvar g;
generate
    for (g = 0; g < 2; g++) begin : g_acc
        wire hit_t = (a_hi_ld | a_lo_ld) && (at_sel == g[0]);
        wire hit_f = fn_wr && (ad_sel == g[0]);
        wire wipe_lo = ~low_half_clear_ctrl_i[g];               // [RQ16]
        wire [`MAD_ACC_W-1:0] ld_v = a_hi_ld
            ? {{`MAD_GUARD{ram_rdata_i[15]}}, ram_rdata_i,
               wipe_lo ? `MAD_HALF0 : acc_cur[g][15:0]}          // [RQ19]
            : {acc_cur[g][35:16], ram_rdata_i};                  // [RQ17]
        assign next_acc[g] = hit_t ? ld_v : hit_f ? res : acc_cur[g];
    end
endgenerate

// ==========================================================
// sequencing
logic stall;
always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        stall         <= 1'b0;
        instr_ready_o <= 1'b1;
        instr_done_o  <= 1'b0;
        ram_wr_o      <= 1'b0;
    end else begin
        stall         <= take & two_cyc;                     // [RQ7] [RQ8]
        instr_ready_o <= ~(take & two_cyc);
        instr_done_o  <= (take & ~two_cyc) | stall;          // [RQ9] [RQ6]
        ram_wr_o      <= take & is_wr;
    end
end

// ==========================================================
// register state: function and transfer on the same edge [RQ1]
always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        x_o          <= `MAD_HALF0;
        y_o          <= `MAD_REG_RST;
        p_o          <= `MAD_REG_RST;
        accum_zero_o <= `MAD_ACC_RST;
        accum_one_o  <= `MAD_ACC_RST;
        flags_o      <= 4'h0;
        ram_waddr_o  <= `MAD_HALF0;
        ram_wdata_o  <= `MAD_HALF0;
        rom_pointer_o <= `MAD_HALF0;
    end else if (take) begin
        y_o          <= next_y;
        accum_zero_o <= next_acc[0];
        accum_one_o  <= next_acc[1];
        if (x_ld) begin
            x_o <= next_x;                                   // [RQ4]
        end
        if (is_mul) begin
            p_o <= product;                                  // [RQ4]
        end
        if (fn_flags) begin
            flags_o <= next_flags;                           // [RQ21]
        end
        if (is_wr) begin
            ram_waddr_o <= next_waddr;
            ram_wdata_o <= next_wdata;
        end
        if (uses_x) begin
            rom_pointer_o <= next_rom;                       // [RQ12]
        end
    end
end

generate
    for (g = 0; g < 4; g++) begin : g_ptr
        always_ff @(posedge clock_i or negedge rst_n) begin
            if (!rst_n) begin
                ram_pointer_reg_o[g] <= `MAD_HALF0;
            end else if (take && uses_rp && (psel == g[1:0])) begin
                ram_pointer_reg_o[g] <= next_rp;             // [RQ13] [RQ14]
            end
        end
    end
endgenerate

// ==========================================================
// checks
default clocking cb @(posedge clock_i); endclocking
default disable iff (!rst_n);

wire nop_take = take && (instr_i == `MAD_NOP);
wire no_xf    = take && (xf == T_NONE);

sequence s_two_cycle;
    !instr_ready_o && !instr_done_o ##1 instr_ready_o && instr_done_o;
endsequence
sequence s_wr_pulse;
    ram_wr_o ##1 !ram_wr_o;
endsequence

property p_wr_two;
    take && is_wr |=> s_two_cycle;
endproperty
a_wr_two: assert property (p_wr_two) else $error("ram write not two cycles"); // [RQ7]

property p_dual_out;
    take && is_dual && !in_cache_i |=> s_two_cycle;
endproperty
a_dual_out: assert property (p_dual_out) else $error("dual read uncached"); // [RQ8]

property p_dual_in;
    take && is_dual && in_cache_i |=> instr_ready_o && instr_done_o;
endproperty
a_dual_in: assert property (p_dual_in) else $error("dual read cached"); // [RQ8]

property p_single;
    no_xf |=> instr_ready_o && instr_done_o;
endproperty
a_single: assert property (p_single) else $error("no transfer not one cycle"); // [RQ9]

property p_nop;
    nop_take |=> $stable(accum_zero_o) && $stable(accum_one_o) && $stable(y_o)
        && $stable(x_o) && $stable(p_o) && $stable(flags_o) && instr_done_o;
endproperty
a_nop: assert property (p_nop) else $error("nop changed state"); // [RQ10]

property p_mul;
    take && is_mul |=> p_o == 32'($signed($past(x_o)) * $signed($past(y_o[31:16])));
endproperty
a_mul: assert property (p_mul) else $error("product wrong"); // [RQ3]

property p_yl_keep;
    take && y_lo_ld |=> y_o[31:16] == $past(y_o[31:16])
        && y_o[15:0] == $past(ram_rdata_i);
endproperty
a_yl_keep: assert property (p_yl_keep) else $error("y high half changed"); // [RQ17]

property p_y_clear;
    take && y_hi_ld && !low_half_clear_ctrl_i[`MAD_LOWCLR_Y] |=> y_o[15:0] == `MAD_HALF0;
endproperty
a_y_clear: assert property (p_y_clear) else $error("y low half kept"); // [RQ16]

property p_flags_keep;
    take && !fn_flags |=> $stable(flags_o);
endproperty
a_flags_keep: assert property (p_flags_keep) else $error("flags moved"); // [RQ21]

property p_cmp;
    no_xf && (fn == F_CMPSUB || fn == F_CMPAND)
        |=> $stable(accum_zero_o) && $stable(accum_one_o);
endproperty
a_cmp: assert property (p_cmp) else $error("compare wrote accumulator"); // [RQ20]

property p_z_wb;
    take && is_z |=> s_wr_pulse and (ram_waddr_o == $past(rp_mid));
endproperty
a_z_wb: assert property (p_z_wb) else $error("compound write-back wrong"); // [RQ15]

property p_rom;
    take && uses_x |=> rom_pointer_o
        == $past(rom_pointer_o) + ($past(xm) ? $past(rom_step_i) : `MAD_PLUS1);
endproperty
a_rom: assert property (p_rom) else $error("rom pointer step wrong"); // [RQ12]

endmodule
`default_nettype wire

// ---- pkg/mad_consts.svh ----
/*
  Field positions, widths and reset values of the multiply/ALU datapath.
  Assumes inclusion by bare name from the package and the core.
*/
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH
// ==========================================================
// instruction word layout
`define MAD_IW      20
`define MAD_F_HI    19
`define MAD_F_LO    16
`define MAD_T_HI    15
`define MAD_T_LO    11
`define MAD_AS_BIT  10
`define MAD_AD_BIT  9
`define MAD_AT_BIT  8
`define MAD_PSEL_HI 7
`define MAD_PSEL_LO 6
`define MAD_YM_HI   5
`define MAD_YM_LO   4
`define MAD_XM_BIT  3
`define MAD_NOP     20'h00000
// ==========================================================
// widths and values
`define MAD_ACC_W   36
`define MAD_REG_W   32
`define MAD_HW      16
`define MAD_GUARD   4
`define MAD_ACC_RST 36'h000000000
`define MAD_REG_RST 32'h00000000
`define MAD_HALF0   16'h0000
`define MAD_PLUS1   16'h0001
`define MAD_MINUS1  16'hFFFF
`define MAD_PLUS2   16'h0002
`define MAD_LOWCLR_ACC0 0
`define MAD_LOWCLR_ACC1 1
`define MAD_LOWCLR_Y    2
`endif

// ---- pkg/mad_pkg.sv ----
/*
  Types of the multiply/ALU datapath: function, transfer and pointer modes.
  Assumes mad_consts.svh on the include path.
*/
`include "mad_consts.svh"
// ==========================================================
// decode types
package mad_pkg;
    typedef enum logic [3:0] {
        F_NONE, F_MUL, F_LDP_MUL, F_ADDP_MUL, F_SUBP_MUL, F_LDP, F_ADDP, F_SUBP,
        F_LDY, F_ADDY, F_SUBY, F_ANDY, F_ORY, F_XORY, F_CMPSUB, F_CMPAND
    } mad_func_t;
    typedef enum logic [4:0] {
        T_NONE, T_LDY_X, T_YACC_X, T_LDYL, T_LDACC, T_LDACCL, T_LDX, T_MOD,
        T_STY, T_STYL, T_STACC, T_STACCL, T_ZY_X, T_ZY, T_ZYL, T_ZACC, T_ZACCL
    } mad_xfer_t;
    typedef enum logic [1:0] {
        compound_read_then_incr, compound_incr_then_write,
        compound_decr_then_plus_two, compound_step_pair
    } mad_zmode_t;
endpackage

// ---- test/mad_mem_model.sv ----
/*
  Sequencer-side memory model: ROM and RAM words seen by the datapath.
  Assumes only the low 8 address bits decode; RAM writes land on the write pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module mad_mem_model (
    input  wire logic        clock_i,    // datapath clock
    input  wire logic        valid_i,    // word offered
    input  wire logic [1:0]  sel_i,      // ram pointer index
    input  wire logic [15:0] rom_addr_i, // rom pointer
    input  wire logic [63:0] ram_ptrs_i, // four pointers
    input  wire logic        wr_en_i,    // write pulse
    input  wire logic [15:0] waddr_i,    // write address
    input  wire logic [15:0] wdata_i,    // write data
    output var  logic [15:0] rom_data_o, // rom word
    output var  logic [15:0] ram_data_o  // ram word
);
    logic [15:0] rom [256];
    logic [15:0] ram [256];
    logic [15:0] rom_w;
    logic [15:0] ram_w;
    initial begin
        for (int n = 0; n < 256; n++) begin
            rom[n] = 16'(n * 16'h9E37);
            ram[n] = 16'(n * 16'h1EEF + 16'h8001);
        end
    end
    assign rom_w = rom[rom_addr_i[7:0]];
    assign ram_w = ram[ram_ptrs_i[sel_i*16 +: 8]];
    // nothing offered: inverted words, so a stale value never looks valid
    assign rom_data_o = valid_i ? rom_w : ~rom_w;
    assign ram_data_o = valid_i ? ram_w : ~ram_w;
    always @(posedge clock_i) begin
        if (wr_en_i) begin
            ram[waddr_i[7:0]] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// ---- test/mad_core_tb.sv ----
/*
  Self-checking bench of the multiply/ALU datapath: corners, then seeded
  random words, checked against a reference kept here.
  Assumes mad_mem_model stands in for the sequencer's ROM and RAM.
*/
`timescale 1ns/1ns
`default_nettype none
module mad_core_tb import mad_pkg::*;;
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        valid = 1'b0;
    logic        cache = 1'b0;
    logic [19:0] instr = 20'h00000;
    logic [15:0] rstep = 16'h0000, jstep = 16'h0000, kstep = 16'h0000;
    logic [2:0]  lo_clear = 3'h0;
    logic [15:0] rom_d, ram_d, waddr, wdata, ptr_o, x_o;
    logic [3:0][15:0] rp_o;
    logic [31:0] y_o, p_o;
    logic [35:0] acc0_o, acc1_o;
    logic [3:0]  flags;
    logic        ready, done, ram_wr;
    int          errors = 0;
    int          compares = 0;
    integer      seed = 32'h2087;
    logic [15:0] ex = 16'h0000, ept = 16'h0000;
    logic [31:0] ey = 32'h00000000, ep = 32'h00000000;
    logic [35:0] ea [2] = '{default: 36'h000000000};
    logic [15:0] er [4] = '{default: 16'h0000};
    logic [3:0]  ef = 4'h0;
    logic [19:0] iw;

    always #5 clock_i = ~clock_i;

    mad_core uut (.clock_i(clock_i), .resetn_i(resetn_i), .instr_valid_i(valid),
        .instr_i(instr), .in_cache_i(cache), .rom_rdata_i(rom_d), .ram_rdata_i(ram_d),
        .rom_step_i(rstep), .ram_step_j_i(jstep), .ram_step_k_i(kstep),
        .low_half_clear_ctrl_i(lo_clear), .instr_ready_o(ready), .instr_done_o(done),
        .ram_wr_o(ram_wr), .ram_waddr_o(waddr), .ram_wdata_o(wdata), .rom_pointer_o(ptr_o),
        .ram_pointer_reg_o(rp_o), .x_o(x_o), .y_o(y_o), .p_o(p_o),
        .accum_zero_o(acc0_o), .accum_one_o(acc1_o), .flags_o(flags));
    mad_mem_model u_mem (.clock_i(clock_i), .valid_i(valid), .sel_i(instr[7:6]),
        .rom_addr_i(ptr_o), .ram_ptrs_i(rp_o), .wr_en_i(ram_wr), .waddr_i(waddr),
        .wdata_i(wdata), .rom_data_o(rom_d), .ram_data_o(ram_d));

    // ======================================================
    // checking
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [35:0] sext32(input logic [31:0] v);
        sext32 = {{4{v[31]}}, v};
    endfunction

    task automatic compare_state;
        chk("x", 36'(x_o), 36'(ex));
        chk("y", 36'(y_o), 36'(ey));
        chk("p", 36'(p_o), 36'(ep));
        chk("acc0", acc0_o, ea[0]);
        chk("acc1", acc1_o, ea[1]);
        chk("rom_ptr", 36'(ptr_o), 36'(ept));
        for (int g = 0; g < 4; g++) begin
            chk("ram_ptr", 36'(rp_o[g]), 36'(er[g]));
        end
        chk("flags", 36'(flags), 36'(ef));
    endtask

    task automatic close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ======================================================
    // one instruction, offered at a falling edge; reference updated alongside
    task automatic run(input logic [19:0] w, input logic c, input logic [2:0] cl);
        logic [3:0]  f;
        logic [4:0]  t;
        logic        s, d, a, two, wr, lv;
        logic [1:0]  m, ym;
        logic [15:0] xv, yv, hv, p0, p1, wa, wd;
        logic [35:0] sp, sy, av, r, op;
        logic [36:0] e;
        int          n;
        chk("ready", 36'(ready), 36'h1);
        instr = w;
        valid = 1'b1;
        cache = c;
        lo_clear = cl;
        rstep = 16'($random(seed));
        jstep = 16'($random(seed));
        kstep = 16'($random(seed));
        {f, t, s, d, a, m, ym} = w[19:4];
        xv = u_mem.rom[ept[7:0]];
        yv = u_mem.ram[er[m][7:0]];
        hv = t == 5'h02 ? ea[a][31:16] : yv;
        sp = sext32(ep);
        sy = sext32(ey);
        av = ea[s];
        p0 = ym == 2'h0 ? 16'h0000 : ym == 2'h1 ? 16'h0001 : ym == 2'h2 ? 16'hFFFF : jstep;
        p1 = ym == 2'h0 ? 16'h0001 : ym == 2'h1 ? 16'h0000 : ym == 2'h2 ? 16'h0002 : kstep;
        wr = t >= 5'h08;
        two = wr || (t inside {5'h01, 5'h02} && !c);
        wa = t >= 5'h0C ? er[m] + p0 : er[m];
        case (t)
            5'h08, 5'h0C, 5'h0D: wd = ey[31:16];
            5'h09, 5'h0E: wd = ey[15:0];
            5'h0A, 5'h0F: wd = ea[a][31:16];
            default: wd = ea[a][15:0];
        endcase
        case (f)
            4'h2, 4'h5: r = sp;
            4'h3, 4'h6: r = av + sp;
            4'h4, 4'h7: r = av - sp;
            4'h8: r = sy;
            4'h9: r = av + sy;
            4'hA, 4'hE: r = av - sy;
            4'hB, 4'hF: r = av & sy;
            4'hC: r = av | sy;
            default: r = av ^ sy;
        endcase
        // 36-bit overflow: the exact 37-bit result disagrees with its bit 35
        op = f inside {[4'h2:4'h7]} ? sp : sy;
        e = f inside {4'h3, 4'h6, 4'h9} ? {av[35], av} + {op[35], op}
                                        : {av[35], av} - {op[35], op};
        lv = f inside {4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'hA, 4'hE} && e[36] != e[35];
        if (f inside {[4'h1:4'h4]}) ep = 32'($signed(ex) * $signed(ey[31:16]));
        if (f inside {[4'h2:4'hD]}) ea[d] = r;
        if (f >= 4'h2) ef = {~(&r[35:31] | ~|r[35:31]), lv, r == 36'h0, r[35]};
        if (t inside {5'h01, 5'h02, 5'h0C}) begin
            ex = xv;
            ept = ept + (w[3] ? rstep : 16'h0001);
        end
        if (t inside {5'h01, 5'h02, 5'h0C, 5'h0D}) ey = {hv, cl[2] ? ey[15:0] : 16'h0000};
        if (t inside {5'h03, 5'h0E}) ey[15:0] = yv;
        if (t inside {5'h04, 5'h0F}) ea[a] = {{4{yv[15]}}, yv, cl[a] ? ea[a][15:0] : 16'h0000};
        if (t inside {5'h05, 5'h10}) ea[a][15:0] = yv;
        if (t == 5'h06) ex = yv;
        if (t != 5'h00 && t != 5'h02) er[m] = er[m] + p0 + (t >= 5'h0C ? p1 : 16'h0000);
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
            if (n == 1) begin
                chk("write", 36'(ram_wr), 36'(wr));
                chk("ready_hold", 36'(ready), 36'(!two));
                if (wr) chk("waddr", 36'(waddr), 36'(wa));
                if (wr) chk("wdata", 36'(wdata), 36'(wd));
            end
        end while (done !== 1'b1 && n < 4);
        chk("cycles", 36'(n), two ? 36'h2 : 36'h1);
        compare_state();
    endtask

    // ======================================================
    // main sequence
    initial begin
        repeat (4) @(negedge clock_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clock_i);
        chk("reset_ctl", 36'({ready, done, ram_wr}), 36'h4);
        compare_state();
        run(20'h00000, 1'b0, 3'h0);
        for (int i = 0; i < 17; i++) begin
            run({4'(i), 5'(i), 11'h528}, 1'(i), 3'h5);
        end
        run({F_NONE, T_LDY_X, 11'h018}, 1'b1, 3'h0);
        run({F_ADDP_MUL, T_LDY_X, 11'h018}, 1'b1, 3'h7);
        run({F_ADDP_MUL, T_LDY_X, 11'h018}, 1'b0, 3'h7);
        run({F_ADDY, T_LDACC, 11'h000}, 1'b0, 3'h0);
        run({F_CMPSUB, T_LDYL, 11'h400}, 1'b1, 3'h4);
        run({F_CMPAND, T_STACCL, 11'h500}, 1'b1, 3'h0);
        run({F_CMPAND, T_NONE, 11'h600}, 1'b0, 3'h2);
        run({F_CMPSUB, T_NONE, 11'h400}, 1'b1, 3'h0);
        for (int z = 0; z < 4; z++) begin
            run({F_SUBY, T_ZY_X, 3'h0, 2'h1, 2'(z), 4'h8}, 1'b1, 3'h3);
        end
        repeat (300) begin
            iw = 20'($random(seed));
            iw[15:11] = 5'($unsigned($random(seed)) % 17);
            // a function result goes to the other accumulator when the transfer loads one
            if (iw[15:11] inside {5'h04, 5'h05, 5'h0F, 5'h10} && iw[19:16] inside {[4'h2:4'hD]})
                iw[9] = ~iw[8];
            run(iw, 1'($random(seed)), 3'($random(seed)));
        end
        valid = 1'b0;
        repeat (2) @(negedge clock_i);
        close_out();
    end

    initial begin
        #100000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
